// ---- core/iop_top.sv ----
// I/O ports with counters, timestamps, pin sharing and six clock blocks.
`timescale 1ns/1ps
`default_nettype none
`include "iop_defs.svh"
module iop_top
  import iop_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [7:0] pad_i,
  output logic [7:0] pad_o,
  output logic [7:0] pad_oe_o,
  input wire logic clk_port_i,
  input wire logic strobe_in_i,
  output logic strobe_out_o,
  output logic [1:0] event_o,
  output logic irq_o
);
  // Merges write data into a register by byte lane.
  function automatic logic [31:0] wmerge(input logic [31:0] old_v, input logic [31:0] new_v,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction

  // Compares the word part of a byte address.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    return adr[7:2] == ofs[7:2];
  endfunction

  // Tells whether the sampled pins meet the programmed condition.
  function automatic logic cond_met(input iop_cond_t mode, input logic [7:0] pins,
                                    input logic [7:0] val);
    logic r;
    case (mode)
      IOP_COND_EQ: r = (pins == val);
      IOP_COND_NEQ: r = (pins != val);
      default: r = 1'b1;
    endcase
    return r;
  endfunction

  // Pin synchronisers.
  logic [7:0] pad_s1_reg, pad_s2_reg;
  logic [1:0] aux_s1_reg, aux_s2_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_s1_reg <= 8'h00;
      pad_s2_reg <= 8'h00;
      aux_s1_reg <= 2'h0;
      aux_s2_reg <= 2'h0;
    end else begin
      pad_s1_reg <= pad_i;
      pad_s2_reg <= pad_s1_reg;
      aux_s1_reg <= {strobe_in_i, clk_port_i};
      aux_s2_reg <= aux_s1_reg;
    end
  end
  logic ext_clk_s;
  logic strobe_in_s;
  assign ext_clk_s = aux_s2_reg[0];
  assign strobe_in_s = aux_s2_reg[1];

  // Bus slave: every access is answered one cycle after it is presented.
  logic ack_reg;
  logic [31:0] dat_reg;
  logic req, wr, rd;
  logic [31:0] rd_word;
  assign req = wb_cyc_i & wb_stb_i & ~ack_reg;
  assign wr = req & wb_we_i;
  assign rd = req & ~wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= req; // RL17
      if (rd) begin
        dat_reg <= rd_word;
      end
    end
  end

  // Link enable and clock block configuration.
  logic link_en_reg;
  logic [9:0] clkb_reg [`IOP_NCLK];
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_en_reg <= 1'b0;
      for (int n = 0; n < `IOP_NCLK; n++) begin
        clkb_reg[n] <= `IOP_CLKB_RST;
      end
    end else if (wr) begin
      if (hit(wb_adr_i, `IOP_OFS_LINK) && wb_sel_i[0]) begin
        link_en_reg <= wb_dat_i[0];
      end
      for (int n = 1; n < `IOP_NCLK; n++) begin
        if (hit(wb_adr_i, `IOP_OFS_CLKB + 8'(4 * n))) begin
          clkb_reg[n] <= 10'(wmerge(32'(clkb_reg[n]), wb_dat_i, wb_sel_i)); // RL12
        end
      end
    end
  end

  // Clock blocks; block 0 always runs from the reference clock.
  logic [`IOP_NCLK-1:0] tick;
  genvar n;
  generate
    for (n = 0; n < `IOP_NCLK; n++) begin : g_clkb
      if (n == 0) begin : g_ref
        iop_clkblk u_blk (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .en_i(1'b1),
          .ext_sel_i(1'b0),
          .div_i(8'(`IOP_REF_DIV - 1)),
          .ext_clk_i(ext_clk_s),
          .tick_o(tick[n])
        ); // RL11
      end else begin : g_prog
        iop_clkblk u_blk (
          .clk_i(clk_i),
          .rst_i(rst_i),
          .en_i(clkb_reg[n][`IOP_CLKB_EN]),
          .ext_sel_i(clkb_reg[n][`IOP_CLKB_EXT]),
          .div_i(clkb_reg[n][`IOP_CLKB_DIV_LO +: 8]),
          .ext_clk_i(ext_clk_s),
          .tick_o(tick[n])
        ); // RL12 RL13
      end
    end
  endgenerate

  // Per-port state seen by the shared logic.
  logic [31:0] port_rd [`IOP_NPORT];
  logic [`IOP_NPORT-1:0] port_ev, port_tick;
  logic [`IOP_NPORT-1:0] port_en, port_dir, port_oc, port_strb;
  logic [7:0] port_pin [`IOP_NPORT];

  genvar p;
  generate
    for (p = 0; p < `IOP_NPORT; p++) begin : g_port
      localparam logic [7:0] WMASK = (p == 0) ? `IOP_NARROW_MASK : `IOP_WIDE_MASK;
      logic [31:0] ctrl_reg;
      logic [7:0] out_reg, in_reg, pin_reg, cond_reg;
      logic out_pend_reg, in_armed_reg;
      iop_cnt_t cnt_reg, ts_reg, time_reg;
      logic sel_port, wr_ctrl, wr_data, rd_data, ptick;
      logic timed_ok, strobe_ok, do_out, do_in;
      logic [2:0] clksel;
      logic [7:0] pins;
      logic [31:0] rword;

      assign sel_port = (wb_adr_i[7:`IOP_PORT_STRIDE_LSB] == 3'(p));
      assign wr_ctrl = wr & sel_port & hit({3'h0, wb_adr_i[4:0]}, `IOP_OFS_CTRL);
      assign wr_data = wr & sel_port & hit({3'h0, wb_adr_i[4:0]}, `IOP_OFS_DATA);
      assign rd_data = rd & sel_port & hit({3'h0, wb_adr_i[4:0]}, `IOP_OFS_DATA);
      assign clksel = ctrl_reg[`IOP_CTRL_CLKSEL_LO +: 3];
      assign ptick = (clksel < 3'(`IOP_NCLK)) ? tick[clksel] : 1'b0; // RL15
      // A wider port still samples all its pins, shared or not.
      assign pins = pad_s2_reg & WMASK; // RL10
      assign timed_ok = ~ctrl_reg[`IOP_CTRL_TIMED] | (cnt_reg == time_reg); // RL6
      assign strobe_ok = ~ctrl_reg[`IOP_CTRL_STROBE] | strobe_in_s; // RL14
      assign do_out = ptick & ctrl_reg[`IOP_CTRL_EN] & ctrl_reg[`IOP_CTRL_DIR]
                      & out_pend_reg & timed_ok; // RL2 RL5
      assign do_in = ptick & ctrl_reg[`IOP_CTRL_EN] & ~ctrl_reg[`IOP_CTRL_DIR] & in_armed_reg
                     & timed_ok & strobe_ok
                     & cond_met(iop_cond_t'(ctrl_reg[`IOP_CTRL_COND_LO +: 2]), pins,
                                cond_reg & WMASK); // RL2 RL5

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          ctrl_reg <= `IOP_CTRL_RST; // RL15
          time_reg <= 16'h0000;
          cond_reg <= 8'h00;
        end else if (wr & sel_port) begin
          if (wr_ctrl) begin
            ctrl_reg <= wmerge(ctrl_reg, wb_dat_i, wb_sel_i) & `IOP_CTRL_MASK;
          end
          if (hit({3'h0, wb_adr_i[4:0]}, `IOP_OFS_TIME)) begin
            time_reg <= 16'(wmerge(32'(time_reg), wb_dat_i, wb_sel_i)); // RL6
          end
          if (hit({3'h0, wb_adr_i[4:0]}, `IOP_OFS_COND)) begin
            cond_reg <= 8'(wmerge(32'(cond_reg), wb_dat_i, wb_sel_i)); // RL2
          end
        end
      end

      // Transfer register and pin register; a new bus write wins over the drain.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          out_reg <= 8'h00;
          out_pend_reg <= 1'b0;
          pin_reg <= 8'h00;
          in_reg <= 8'h00;
          in_armed_reg <= 1'b0;
        end else begin
          if (do_out) begin
            pin_reg <= out_reg; // RL4
          end
          if (wr_data) begin
            out_reg <= wb_dat_i[7:0] & WMASK; // RL10
            out_pend_reg <= 1'b1;
          end else if (do_out) begin
            out_pend_reg <= 1'b0;
          end
          if (do_in) begin
            in_reg <= pins; // RL4 RL10
          end
          if (wr_ctrl || rd_data) begin
            in_armed_reg <= 1'b1;
          end else if (do_in) begin
            in_armed_reg <= 1'b0;
          end
        end
      end

      // Port counter and timestamp.
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          cnt_reg <= 16'h0000;
          ts_reg <= 16'h0000;
        end else begin
          if (ptick) begin
            cnt_reg <= cnt_reg + 16'h0001; // RL5 RL18
          end
          if (do_out || do_in) begin
            ts_reg <= cnt_reg; // RL7
          end
        end
      end

      always_comb begin
        rword = 32'h00000000;
        case ({3'h0, wb_adr_i[4:2], 2'h0})
          `IOP_OFS_CTRL: rword = ctrl_reg;
          `IOP_OFS_DATA: rword = {24'h000000, in_reg};
          `IOP_OFS_CNT: rword = {16'h0000, cnt_reg}; // RL6
          `IOP_OFS_TS: rword = {16'h0000, ts_reg}; // RL7
          `IOP_OFS_TIME: rword = {16'h0000, time_reg};
          `IOP_OFS_COND: rword = {24'h000000, cond_reg};
          default: rword = 32'h00000000;
        endcase
      end

      assign port_rd[p] = rword;
      assign port_ev[p] = do_out | do_in; // RL16
      assign port_tick[p] = ptick;
      assign port_en[p] = ctrl_reg[`IOP_CTRL_EN];
      assign port_dir[p] = ctrl_reg[`IOP_CTRL_DIR]; // RL1
      assign port_oc[p] = ctrl_reg[`IOP_CTRL_OC];
      assign port_strb[p] = ctrl_reg[`IOP_CTRL_STROBE];
      assign port_pin[p] = pin_reg;
    end
  endgenerate

  // Pin ownership: link first, then the narrow port, then the wide port.
  logic [7:0] pad_o_next, pad_oe_next;
  logic [7:0] pad_o_reg, pad_oe_reg;
  always_comb begin
    pad_o_next = 8'h00;
    pad_oe_next = 8'h00;
    for (int i = 0; i < `IOP_NPIN; i++) begin
      if (link_en_reg && i >= `IOP_LINK_LO) begin
        pad_oe_next[i] = 1'b0; // RL8
      end else if (i < 4 && port_en[0]) begin
        if (port_dir[0]) begin // RL9
          pad_o_next[i] = port_oc[0] ? 1'b0 : port_pin[0][i];
          pad_oe_next[i] = port_oc[0] ? ~port_pin[0][i] : 1'b1; // RL3
        end
      end else if (port_en[1] && port_dir[1]) begin
        pad_o_next[i] = port_oc[1] ? 1'b0 : port_pin[1][i];
        pad_oe_next[i] = port_oc[1] ? ~port_pin[1][i] : 1'b1; // RL3
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pad_o_reg <= 8'h00;
      pad_oe_reg <= 8'h00;
    end else begin
      pad_o_reg <= pad_o_next;
      pad_oe_reg <= pad_oe_next;
    end
  end

  // Output strobe of the wide port: up with the new pin values, down at the next port clock.
  logic strobe_out_reg;
  logic [1:0] event_reg, stat_reg, mask_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      strobe_out_reg <= 1'b0;
    end else if (event_reg[1] && port_dir[1] && port_strb[1]) begin
      strobe_out_reg <= 1'b1; // RL14
    end else if (port_tick[1]) begin
      strobe_out_reg <= 1'b0;
    end
  end

  // Events, sticky status, mask and interrupt.
  logic irq_reg;
  logic [1:0] stat_clr;
  assign stat_clr = (wr && hit(wb_adr_i, `IOP_OFS_IRQ_STAT) && wb_sel_i[0]) ? wb_dat_i[1:0] : 2'h0;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      event_reg <= 2'h0;
      stat_reg <= 2'h0;
      irq_reg <= 1'b0;
    end else begin
      event_reg <= port_ev; // RL16
      stat_reg <= (stat_reg & ~stat_clr) | port_ev;
      irq_reg <= |(stat_reg & mask_reg);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_reg <= `IOP_MASK_RST;
    end else if (wr && hit(wb_adr_i, `IOP_OFS_IRQ_MASK) && wb_sel_i[0]) begin
      mask_reg <= wb_dat_i[1:0];
    end
  end

  // Read multiplexer; unmapped words read as zero.
  always_comb begin
    rd_word = 32'h00000000;
    if (wb_adr_i[7:`IOP_PORT_STRIDE_LSB] < 3'(`IOP_NPORT)) begin
      rd_word = port_rd[wb_adr_i[`IOP_PORT_STRIDE_LSB]];
    end else if (hit(wb_adr_i, `IOP_OFS_LINK)) begin
      rd_word = {31'h00000000, link_en_reg};
    end else if (hit(wb_adr_i, `IOP_OFS_IRQ_STAT)) begin
      rd_word = {30'h00000000, stat_reg};
    end else if (hit(wb_adr_i, `IOP_OFS_IRQ_MASK)) begin
      rd_word = {30'h00000000, mask_reg};
    end else begin
      for (int k = 1; k < `IOP_NCLK; k++) begin
        if (hit(wb_adr_i, `IOP_OFS_CLKB + 8'(4 * k))) begin
          rd_word = {22'h000000, clkb_reg[k]};
        end
      end
    end
  end

  assign wb_dat_o = dat_reg;
  assign wb_ack_o = ack_reg;
  assign pad_o = pad_o_reg;
  assign pad_oe_o = pad_oe_reg;
  assign strobe_out_o = strobe_out_reg;
  assign event_o = event_reg;
  assign irq_o = irq_reg;
endmodule // iop_top
`default_nettype wire

// ---- core/iop_defs.svh ----
// Constants for the I/O port block with its clock blocks.
// What this block does
// RL1: Ports are 4 or 8 pins, one direction.
// RL2: Ports drive pins or sample, optionally conditioned.
// RL3: Open-collector: zero drives low, one floats.
// RL4: Data passes transfer register and pin register.
// RL5: 16-bit counter times each pin transfer.
// RL6: Counter readable; transfers deferrable to set time.
// RL7: Each transfer stores the counter as timestamp.
// RL8: Enabled link disables ports on shared pins.
// RL9: Narrower port overrides wider port's shared pins.
// RL10: Ports always transfer their full width.
// RL11: Six clock blocks; block 0 is reference.
// RL12: Blocks 1 to 5 run at own rates.
// RL13: Block may use 1-bit pin, optionally divided.
// RL14: Input strobe honoured; output strobe generated.
// RL15: After reset every port uses block 0.
// RL16: Port events go straight to event output.
// RL17: Every port access completes in one cycle.
// RL18: Counter steps per clock tick, wraps to zero.
`ifndef IOP_DEFS_SVH
`define IOP_DEFS_SVH

`define IOP_NPORT 2
`define IOP_NPIN 8
`define IOP_NCLK 6
`define IOP_CNT_W 16
`define IOP_LINK_LO 4
`define IOP_NARROW_MASK 8'h0f
`define IOP_WIDE_MASK 8'hff

`define IOP_CLK_HZ 100000000
`define IOP_REF_HZ 100000000
`define IOP_REF_DIV (`IOP_CLK_HZ / `IOP_REF_HZ)

`define IOP_PORT_STRIDE_LSB 5
`define IOP_OFS_CTRL 8'h00
`define IOP_OFS_DATA 8'h04
`define IOP_OFS_CNT 8'h08
`define IOP_OFS_TS 8'h0c
`define IOP_OFS_TIME 8'h10
`define IOP_OFS_COND 8'h14
`define IOP_OFS_LINK 8'h40
`define IOP_OFS_CLKB 8'h50
`define IOP_OFS_IRQ_STAT 8'h80
`define IOP_OFS_IRQ_MASK 8'h84

`define IOP_CTRL_EN 0
`define IOP_CTRL_DIR 1
`define IOP_CTRL_OC 2
`define IOP_CTRL_TIMED 3
`define IOP_CTRL_STROBE 4
`define IOP_CTRL_CLKSEL_LO 8
`define IOP_CTRL_COND_LO 12
`define IOP_CTRL_MASK 32'h0000371f
`define IOP_CTRL_RST 32'h00000000

`define IOP_CLKB_DIV_LO 0
`define IOP_CLKB_EXT 8
`define IOP_CLKB_EN 9
`define IOP_CLKB_MASK 10'h3ff
`define IOP_CLKB_RST 10'h000
`define IOP_MASK_RST 2'h0

`endif

// ---- core/iop_pkg.sv ----
// Types shared by the I/O port block.
package iop_pkg;
  typedef enum logic [1:0] {
    IOP_COND_NONE = 2'h0,
    IOP_COND_EQ = 2'h1,
    IOP_COND_NEQ = 2'h2
  } iop_cond_t;
  typedef logic [15:0] iop_cnt_t;
endpackage

// ---- core/iop_clkblk.sv ----
// One clock block: picks the reference or a pin clock and divides it into ticks.
`timescale 1ns/1ps
`default_nettype none
module iop_clkblk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire logic ext_sel_i,
  input wire logic [7:0] div_i,
  input wire logic ext_clk_i,
  output logic tick_o
);
  logic ext_q_reg;
  logic [7:0] div_cnt_reg;
  logic tick_reg;
  logic src_edge;

  // Rising edge of the synchronised pin clock, or every reference cycle.
  assign src_edge = ext_sel_i ? (ext_clk_i & ~ext_q_reg) : 1'b1; // RL13

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_q_reg <= 1'b0;
    end else begin
      ext_q_reg <= ext_clk_i;
    end
  end

  // The source is divided by div_i plus one.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_cnt_reg <= 8'h00;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= 1'b0;
      if (en_i && src_edge) begin
        if (div_cnt_reg >= div_i) begin // RL12 RL13
          div_cnt_reg <= 8'h00;
          tick_reg <= 1'b1;
        end else begin
          div_cnt_reg <= div_cnt_reg + 8'h01;
        end
      end
    end
  end

  assign tick_o = tick_reg;
endmodule // iop_clkblk
`default_nettype wire

// ---- dv/iop_pad_model.sv ----
// Model of the external hardware on the pins, strobe and pin clock.
`timescale 1ns/1ps
`default_nettype none
module iop_pad_model (
  input wire logic clk_i,
  input wire logic [7:0] pad_o_i,
  input wire logic [7:0] pad_oe_i,
  input wire logic strobe_out_i,
  output logic [7:0] pad_i_o,
  output logic clk_port_o,
  output logic strobe_in_o
);
  logic [7:0] drv_en;
  logic [7:0] drv_val;
  logic [7:0] got;
  initial begin
    drv_en = 8'h00;
    drv_val = 8'h00;
    clk_port_o = 1'b0;
    strobe_in_o = 1'b1;
    got = 8'h00;
  end
  // Undriven pins sit on their pull-down, so a floating one reads low.
  assign pad_i_o = (pad_oe_i & pad_o_i) | (~pad_oe_i & drv_en & drv_val);
  // Output data is taken only while the block's strobe says it is valid.
  always @(posedge clk_i) begin
    if (strobe_out_i === 1'b1) begin
      got <= pad_i_o;
    end
  end
  // The pin clock stands still between bursts of rising edges.
  task automatic pulse(input int n);
    repeat (n) begin
      repeat (4) @(posedge clk_i);
      clk_port_o <= 1'b1;
      repeat (4) @(posedge clk_i);
      clk_port_o <= 1'b0;
    end
  endtask
endmodule // iop_pad_model
`default_nettype wire

// ---- dv/iop_top_checker.sv ----
// Assertions on the ports of the I/O port block.
`timescale 1ns/1ps
`default_nettype none
module iop_top_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic [7:0] pad_oe_o,
  input wire logic [1:0] event_o,
  input wire logic strobe_out_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence s_ack;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  a_ack_next: assert property (s_req |=> s_ack) else $error("ack not one cycle on");
  a_ack_lone: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_rdat_hold: assert property (!(wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o)
    |=> $stable(wb_dat_o)) else $error("read data moved");
  a_reset_quiet: assert property ($fell(rst_i) |-> pad_oe_o == 8'h00 && event_o == 2'h0
    && !irq_o && !strobe_out_o) else $error("outputs busy after reset");
  a_event_pulse: assert property (event_o != 2'h0 |=> (event_o & $past(event_o)) == 2'h0)
    else $error("event longer than a cycle");
  a_strobe_data: assert property ($rose(strobe_out_o) |-> $past(event_o[1]))
    else $error("strobe without transfer");
  a_irq_rise: assert property ($rose(irq_o) |-> $past(wb_ack_o) || $past(event_o != 2'h0))
    else $error("irq rose without cause");
  a_irq_fall: assert property ($fell(irq_o) |-> $past(wb_ack_o))
    else $error("irq fell without write");
  c_strobe: cover property ($rose(strobe_out_o));
endmodule // iop_top_checker
bind iop_top iop_top_checker i_iop_top_checker (.clk_i(clk_i), .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .pad_oe_o(pad_oe_o), .event_o(event_o),
  .strobe_out_o(strobe_out_o), .irq_o(irq_o));
`default_nettype wire

// ---- dv/iop_top_tb.sv ----
// Self-checking bench for the I/O port block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module iop_top_tb import iop_pkg::*;;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, clk_port_i;
  logic strobe_in_i, strobe_out_o, irq_o, ev_ok;
  logic [7:0] wb_adr_i, pad_i, pad_o, pad_oe_o;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, rdat;
  logic [1:0] event_o;
  iop_cnt_t cnt;
  int errors, checks_done;
  iop_top i_iop_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pad_i(pad_i), .pad_o(pad_o),
    .pad_oe_o(pad_oe_o), .clk_port_i(clk_port_i), .strobe_in_i(strobe_in_i),
    .strobe_out_o(strobe_out_o), .event_o(event_o), .irq_o(irq_o));
  iop_pad_model i_iop_pad_model (.clk_i(clk_i), .pad_o_i(pad_o), .pad_oe_i(pad_oe_o),
    .strobe_out_i(strobe_out_o), .pad_i_o(pad_i), .clk_port_o(clk_port_i),
    .strobe_in_o(strobe_in_i));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic summarize;
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic watch(input int p, input int n);
    ev_ok = 1'b0;
    for (int i = 0; i < n; i++) begin
      #1;
      ev_ok = (event_o[p] === 1'b1);
      if (ev_ok) break;
      @(posedge clk_i);
    end
  endtask
  task automatic t_reset;
    `CHK("oe reset", 8'h00, pad_oe_o)
    bus(1'b0, 8'h00, 32'h0);
    `CHK("ctrl0 reset", 32'h0, rdat)
    bus(1'b0, 8'h84, 32'h0);
    `CHK("mask reset", 32'h0, rdat)
    bus(1'b0, 8'hfc, 32'h0);
    `CHK("unmapped", 32'h0, rdat)
  endtask
  task automatic t_out;
    bus(1'b1, 8'h84, 32'h1);
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b0, 8'h08, 32'h0);
    cnt = rdat[15:0];
    bus(1'b0, 8'h08, 32'h0);
    `CHK("ref count", iop_cnt_t'(cnt + 16'd3), rdat[15:0])
    bus(1'b1, 8'h04, 32'h5);
    watch(0, 200);
    `CHK("out0 event", 1'b1, ev_ok)
    step(1);
    `CHK("out0 pins", 4'h5, pad_o[3:0])
    `CHK("out0 oe", 4'hf, pad_oe_o[3:0])
    `CHK("irq set", 1'b1, irq_o)
    bus(1'b0, 8'h80, 32'h0);
    `CHK("status", 32'h1, rdat)
    bus(1'b1, 8'h80, 32'h1);
    step(2);
    `CHK("irq clear", 1'b0, irq_o)
    bus(1'b1, 8'h00, 32'hb);
    bus(1'b0, 8'h08, 32'h0);
    cnt = rdat[15:0] + 16'd80;
    bus(1'b1, 8'h10, {16'h0, cnt});
    bus(1'b1, 8'h04, 32'h6);
    watch(0, 30);
    `CHK("timed early", 1'b0, ev_ok)
    watch(0, 200);
    `CHK("timed event", 1'b1, ev_ok)
    bus(1'b0, 8'h0c, 32'h0);
    `CHK("timestamp", cnt, rdat[15:0])
  endtask
  task automatic t_oc;
    bus(1'b1, 8'h00, 32'h7);
    bus(1'b1, 8'h04, 32'h5);
    watch(0, 200);
    step(1);
    `CHK("oc oe", 4'ha, pad_oe_o[3:0])
    `CHK("oc low", 4'h0, pad_o[3:0] & pad_oe_o[3:0])
  endtask
  task automatic t_share;
    bus(1'b1, 8'h00, 32'h3);
    bus(1'b1, 8'h04, 32'h5);
    watch(0, 200);
    bus(1'b1, 8'h20, 32'h13);
    bus(1'b1, 8'h24, 32'h3c);
    watch(1, 200);
    `CHK("out1 event", 1'b1, ev_ok)
    step(1);
    `CHK("strobe", 1'b1, strobe_out_o)
    `CHK("shared pins", 8'h35, pad_o)
    `CHK("shared oe", 8'hff, pad_oe_o)
    step(1);
    `CHK("strobed data", 8'h35, i_iop_pad_model.got)
    bus(1'b1, 8'h40, 32'h1);
    step(2);
    `CHK("link oe", 8'h0f, pad_oe_o)
    bus(1'b1, 8'h40, 32'h0);
  endtask
  task automatic t_in;
    bus(1'b1, 8'h20, 32'h0);
    i_iop_pad_model.drv_en <= 8'h0f;
    i_iop_pad_model.drv_val <= 8'h03;
    bus(1'b1, 8'h14, 32'h9);
    bus(1'b1, 8'h00, 32'h1011);
    watch(0, 30);
    `CHK("cond wait", 1'b0, ev_ok)
    i_iop_pad_model.strobe_in_o <= 1'b0;
    i_iop_pad_model.drv_val <= 8'h09;
    watch(0, 30);
    `CHK("strobe wait", 1'b0, ev_ok)
    i_iop_pad_model.strobe_in_o <= 1'b1;
    watch(0, 200);
    `CHK("cond event", 1'b1, ev_ok)
    bus(1'b0, 8'h04, 32'h0);
    `CHK("in data", 4'h9, rdat[3:0])
  endtask
  task automatic t_clk;
    bus(1'b1, 8'h54, 32'h301);
    bus(1'b1, 8'h00, 32'h101);
    step(10);
    bus(1'b0, 8'h08, 32'h0);
    cnt = rdat[15:0];
    step(10);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("pin clk idle", cnt, rdat[15:0])
    i_iop_pad_model.pulse(8);
    step(10);
    bus(1'b0, 8'h08, 32'h0);
    `CHK("pin clk count", iop_cnt_t'(cnt + 16'd4), rdat[15:0])
  endtask
  initial begin
    #500000;
    errors++;
    summarize();
  end
  initial begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    errors = 0;
    checks_done = 0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_out();
    t_oc();
    t_share();
    t_in();
    t_clk();
    summarize();
  end
endmodule // iop_top_tb
`default_nettype wire
